/* bsts_defs.svh */
// opcode encodings, field positions and reset values of the bit instruction unit
`ifndef BSTS_DEFS_SVH
`define BSTS_DEFS_SVH
`define BSTS_WORD_W 14
`define BSTS_OPC_MSB 13
`define BSTS_OPC_LSB 10
`define BSTS_BIT_MSB 9
`define BSTS_BIT_LSB 7
`define BSTS_ADDR_MSB 6
`define BSTS_ADDR_LSB 0
`define BSTS_OPC_SET 4'h5
`define BSTS_OPC_TSC 4'h6
`define BSTS_OPC_TSS 4'h7
`define BSTS_RST_BIT 1'h0
`define BSTS_RST_ADDR 7'h00
`define BSTS_RST_DATA 8'h00
`endif

/* bsts_pkg.sv */
// types shared by the bit instruction unit
package bsts_pkg;
   typedef logic [13:0] bsts_word_t;
   typedef logic [6:0] bsts_addr_t;
   typedef logic [7:0] bsts_data_t;
   typedef logic [2:0] bsts_bit_t;
   typedef enum logic [1:0] {BSTS_OP_NONE, BSTS_OP_SET, BSTS_OP_TSC, BSTS_OP_TSS} bsts_op_t;
endpackage : bsts_pkg

/* bsts_field_dec.sv */
// field decoder for one instruction word
`timescale 1ns/1ps
`include "bsts_defs.svh"
module bsts_field_dec
   import bsts_pkg::*;
(
   input wire bsts_pkg::bsts_word_t word,     // instruction word
   output bsts_pkg::bsts_op_t op,             // decoded operation
   output bsts_pkg::bsts_addr_t addr,         // register address field
   output bsts_pkg::bsts_data_t mask          // one-hot bit mask
);
   function automatic bsts_data_t bit_mask(input bsts_bit_t idx);
      bit_mask = bsts_data_t'(8'h01 << idx);
   endfunction : bit_mask

   wire [3:0] opc = word[`BSTS_OPC_MSB:`BSTS_OPC_LSB];
   wire bsts_bit_t idx = word[`BSTS_BIT_MSB:`BSTS_BIT_LSB];

   assign addr = word[`BSTS_ADDR_MSB:`BSTS_ADDR_LSB];
   assign mask = bit_mask(idx);
   assign op = (opc == `BSTS_OPC_SET) ? BSTS_OP_SET :
               (opc == `BSTS_OPC_TSC) ? BSTS_OP_TSC :
               (opc == `BSTS_OPC_TSS) ? BSTS_OP_TSS : BSTS_OP_NONE;
endmodule : bsts_field_dec

/* bsts_unit.sv */
// bit set and bit test-and-skip execution unit
// Summary of operation
// - bit_set_op forces indexed bit of addressed register to one, others kept
// - test_skip_if_clear_op skips the next instruction when the tested bit is zero
// - taken clear-skip drops the prefetched word, runs a nop, takes two cycles
// - test_skip_if_set_op skips the next instruction when the tested bit is one
// - taken set-skip drops the prefetched word, runs a nop; untaken is one cycle
`timescale 1ns/1ps
`include "bsts_defs.svh"
module bsts_unit
   import bsts_pkg::*;
(
   input wire logic clk,                          // core instruction clock
   input wire logic sys_rst,                      // synchronous reset, active high
   input wire logic instr_valid,                  // instruction word present this cycle
   input wire bsts_pkg::bsts_word_t instr_word,   // instruction word
   output bsts_pkg::bsts_addr_t rf_raddr,         // register file read address
   input wire bsts_pkg::bsts_data_t rf_rdata,     // register file read data
   output logic rf_we,                            // register file write enable
   output bsts_pkg::bsts_addr_t rf_waddr,         // register file write address
   output bsts_pkg::bsts_data_t rf_wdata,         // register file write data
   output logic skip_flush,                       // drop prefetched word now
   output logic nop_slot,                         // current slot runs as nop
   output logic instr_done                        // instruction completed
);
   import bsts_pkg::*;

   bsts_op_t op;
   bsts_addr_t addr;
   bsts_data_t mask;
   logic wr_en_q;
   bsts_addr_t wr_addr_q;
   bsts_data_t wr_data_q;
   logic nop_slot_q;
   logic done_q;

   bsts_field_dec u_dec
   (
      .word(instr_word),
      .op(op),
      .addr(addr),
      .mask(mask)
   );

   // word arriving in a nop slot is the prefetched one and is discarded
   wire accept = instr_valid & ~nop_slot_q;
   wire bit_val = |(rf_rdata & mask);
   wire bsts_bit_t bit_idx = instr_word[`BSTS_BIT_MSB:`BSTS_BIT_LSB];
   wire is_set = accept & (op == BSTS_OP_SET);
   wire is_tsc = accept & (op == BSTS_OP_TSC);
   wire is_tss = accept & (op == BSTS_OP_TSS);
   wire tsc_take = is_tsc & ~bit_val;
   wire tss_take = is_tss & bit_val;
   wire skip_take = tsc_take | tss_take;
   wire bsts_data_t set_data = rf_rdata | mask;

   assign rf_raddr = addr;
   assign skip_flush = skip_take;
   assign rf_we = wr_en_q;
   assign rf_waddr = wr_addr_q;
   assign rf_wdata = wr_data_q;
   assign nop_slot = nop_slot_q;
   assign instr_done = done_q;

   // write-back of the bit set, one cycle, no flag path exists
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wr_en_q <= `BSTS_RST_BIT;
         wr_addr_q <= `BSTS_RST_ADDR;
         wr_data_q <= `BSTS_RST_DATA;
      end
      else
      begin
         wr_en_q <= is_set;
         if (is_set)
         begin
            wr_addr_q <= addr;
            wr_data_q <= set_data;
         end
      end
   end

   // skip turns the next slot into a nop, so the skip finishes one cycle later
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         nop_slot_q <= `BSTS_RST_BIT;
         done_q <= `BSTS_RST_BIT;
      end
      else
      begin
         nop_slot_q <= skip_take;
         done_q <= (accept & ~skip_take) | nop_slot_q;
      end
   end

   sequence skip_then_nop;
      skip_take ##1 nop_slot_q;
   endsequence

   // accepted word that completes without a skip
   sequence plain_accept;
      accept && !skip_take;
   endsequence

   // discarded word sitting in the nop slot
   sequence dropped_slot;
      nop_slot_q && !accept;
   endsequence

   // accepted bit set followed by its write request
   sequence set_then_write;
      is_set ##1 wr_en_q;
   endsequence

   AST_SET_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
      is_set |=> wr_en_q && wr_addr_q == $past(addr) && wr_data_q[$past(bit_idx)] == 1'b1)
      else $error("bit set did not write the indexed bit high");

   AST_SET_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
      is_set |=> (wr_data_q & ~$past(mask)) == ($past(rf_rdata) & ~$past(mask)))
      else $error("bit set altered other bits");

   AST_TSC_DECIDE: assert property (@(posedge clk) disable iff (sys_rst)
      is_tsc |=> nop_slot_q == !$past(bit_val))
      else $error("clear-skip decision wrong");

   AST_TSS_DECIDE: assert property (@(posedge clk) disable iff (sys_rst)
      is_tss |=> nop_slot_q == $past(bit_val))
      else $error("set-skip decision wrong");

   AST_TSC_TWO_CYCLE: assert property (@(posedge clk) disable iff (sys_rst)
      tsc_take |-> skip_flush ##1 (nop_slot_q && !done_q && !is_set) ##1 done_q)
      else $error("taken clear-skip not two cycles with nop");

   AST_TSS_TWO_CYCLE: assert property (@(posedge clk) disable iff (sys_rst)
      tss_take |-> skip_then_nop ##1 (done_q && !wr_en_q))
      else $error("taken set-skip not two cycles with nop");

   AST_UNTAKEN_ONE: assert property (@(posedge clk) disable iff (sys_rst)
      (is_tss || is_tsc) && !skip_take |=> done_q && !nop_slot_q)
      else $error("untaken skip did not finish in one cycle");

   AST_SET_ONE_CYCLE: assert property (@(posedge clk) disable iff (sys_rst)
      is_set |-> !skip_flush ##1 (done_q && !nop_slot_q))
      else $error("bit set not single cycle");

   // reset checks carry no disable, they watch the reset itself
   AST_RST_NO_WRITE: assert property (@(posedge clk)
      sys_rst |=> !wr_en_q && wr_addr_q == `BSTS_RST_ADDR && wr_data_q == `BSTS_RST_DATA)
      else $error("reset did not clear the write request");

   AST_RST_NO_SLOT: assert property (@(posedge clk)
      sys_rst |=> !nop_slot_q && !done_q)
      else $error("reset did not clear the nop slot");

   AST_NOP_NO_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
      nop_slot_q |=> !wr_en_q)
      else $error("dropped word caused a write");

   AST_NOP_NO_FLUSH: assert property (@(posedge clk) disable iff (sys_rst)
      nop_slot_q |-> !skip_flush)
      else $error("dropped word caused a skip");

   AST_FLUSH_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
      skip_flush |=> !skip_flush)
      else $error("skip flush longer than one cycle");

   AST_SLOT_FROM_SKIP: assert property (@(posedge clk) disable iff (sys_rst)
      nop_slot_q |-> $past(skip_take))
      else $error("nop slot without a taken skip");

   AST_PLAIN_DONE: assert property (@(posedge clk) disable iff (sys_rst)
      plain_accept |=> done_q && !nop_slot_q)
      else $error("plain word did not finish in one cycle");

   AST_SLOT_DONE: assert property (@(posedge clk) disable iff (sys_rst)
      dropped_slot |=> done_q && !wr_en_q)
      else $error("nop slot did not close the skip");

   AST_HOLD_WRITE_REGS: assert property (@(posedge clk) disable iff (sys_rst)
      !is_set |=> $stable(wr_addr_q) && $stable(wr_data_q))
      else $error("write address or data moved without a bit set");

   AST_WE_FROM_SET: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en_q |-> $past(is_set))
      else $error("write request without a bit set");

   AST_SET_NO_SLOT: assert property (@(posedge clk) disable iff (sys_rst)
      set_then_write |-> !nop_slot_q && done_q)
      else $error("bit set opened a nop slot");

   AST_TSC_NO_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
      is_tsc |=> !wr_en_q)
      else $error("clear-skip test wrote a register");

   AST_TSS_NO_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
      is_tss |=> !wr_en_q)
      else $error("set-skip test wrote a register");

   AST_SKIP_NO_DONE: assert property (@(posedge clk) disable iff (sys_rst)
      skip_take |=> !done_q)
      else $error("taken skip finished after one cycle");

   AST_FLUSH_NEEDS_TEST: assert property (@(posedge clk) disable iff (sys_rst)
      skip_flush |-> is_tsc || is_tss)
      else $error("skip flush without a bit test");

   AST_TSC_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
      is_tsc && bit_val |-> !skip_flush)
      else $error("clear-skip skipped on a set bit");

   AST_TSS_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
      is_tss && !bit_val |-> !skip_flush)
      else $error("set-skip skipped on a clear bit");

   // each index position must land on its own bit
   generate
      for (genvar k = 0; k < $bits(bsts_data_t); k++)
      begin : g_set_bit
         AST_SET_BIT: assert property (@(posedge clk) disable iff (sys_rst)
            is_set && bit_idx == 3'(k) |=> wr_data_q[k])
            else $error("bit set missed its index position");
      end
   endgenerate
endmodule : bsts_unit

/* bsts_unit_tb.sv */
// self-checking bench for the bit set and test-and-skip unit
`timescale 1ns/1ps
`include "bsts_defs.svh"
module bsts_unit_tb;
   import bsts_pkg::*;
   logic clk;
   logic sys_rst = 1'b1;
   logic instr_valid = 1'b0;
   bsts_word_t instr_word = 14'h0000;
   bsts_addr_t rf_raddr;
   bsts_data_t rf_rdata = 8'h00;
   logic rf_we;
   bsts_addr_t rf_waddr;
   bsts_data_t rf_wdata;
   logic skip_flush;
   logic nop_slot;
   logic instr_done;
   int bad_count = 0;
   int total_checks = 0;
   bsts_unit dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
      .instr_word(instr_word), .rf_raddr(rf_raddr), .rf_rdata(rf_rdata), .rf_we(rf_we),
      .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .skip_flush(skip_flush),
      .nop_slot(nop_slot), .instr_done(instr_done));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task wrap_up;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   // one word, then a set word to 7f that a skip must drop
   task automatic run_op(input logic [3:0] opc, input bsts_bit_t b, input bsts_addr_t a,
      input bsts_data_t rd, input logic sk);
      logic st;
      st = (opc == `BSTS_OPC_SET);
      @(negedge clk);
      instr_valid = 1'b1;
      instr_word = {opc, b, a};
      rf_rdata = rd;
      #1;
      chk("raddr", 8'(rf_raddr), 8'(a));
      chk("skip_flush", 8'(skip_flush), 8'(sk));
      @(negedge clk);
      instr_word = {`BSTS_OPC_SET, 3'h0, 7'h7f};
      rf_rdata = 8'h00;
      chk("we", 8'(rf_we), 8'(st));
      if (st)
         chk("wdata", rf_wdata, rd | (8'h01 << b));
      if (st)
         chk("waddr", 8'(rf_waddr), 8'(a));
      chk("nop_slot", 8'(nop_slot), 8'(sk));
      chk("done", 8'(instr_done), 8'(!sk));
      @(negedge clk);
      instr_valid = 1'b0;
      chk("we_after", 8'(rf_we), 8'(!sk));
      chk("done_after", 8'(instr_done), 8'h01);
      if (!sk)
         chk("waddr_next", 8'(rf_waddr), 8'h7f);
      if (!sk)
         chk("wdata_next", rf_wdata, 8'h01);
   endtask : run_op
   task test_set;
      for (int i = 0; i < 8; i++)
         run_op(`BSTS_OPC_SET, 3'(i), 7'(8'h78 + i), 8'h0A, 1'b0);
      $display("test_set done");
   endtask : test_set
   task test_clear_skip;
      run_op(`BSTS_OPC_TSC, 3'h3, 7'h05, 8'hF7, 1'b1);
      run_op(`BSTS_OPC_TSC, 3'h3, 7'h05, 8'h08, 1'b0);
      $display("test_clear_skip done");
   endtask : test_clear_skip
   task test_set_skip;
      run_op(`BSTS_OPC_TSS, 3'h7, 7'h00, 8'h80, 1'b1);
      run_op(`BSTS_OPC_TSS, 3'h0, 7'h00, 8'hFE, 1'b0);
      run_op(4'h4, 3'h0, 7'h01, 8'h00, 1'b0);
      $display("test_set_skip done");
   endtask : test_set_skip
   // reset in mid-run while a nop slot is pending
   task test_reset;
      run_op(`BSTS_OPC_SET, 3'h6, 7'h2a, 8'h01, 1'b0);
      @(negedge clk);
      instr_valid = 1'b1;
      instr_word = {`BSTS_OPC_TSS, 3'h0, 7'h2a};
      rf_rdata = 8'h01;
      @(negedge clk);
      instr_valid = 1'b0;
      sys_rst = 1'b1;
      chk("slot_before_rst", 8'(nop_slot), 8'h01);
      @(negedge clk);
      sys_rst = 1'b0;
      chk("rst_slot", 8'(nop_slot), 8'h00);
      chk("rst_we", 8'(rf_we), 8'h00);
      chk("rst_waddr", 8'(rf_waddr), 8'h00);
      chk("rst_wdata", rf_wdata, 8'h00);
      chk("rst_done_mid", 8'(instr_done), 8'h00);
      run_op(`BSTS_OPC_TSS, 3'h0, 7'h2a, 8'h01, 1'b1);
      $display("test_reset done");
   endtask : test_reset
   initial
   begin
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      chk("rst_done", 8'(instr_done), 8'h00);
      test_set();
      test_clear_skip();
      test_set_skip();
      test_reset();
      wrap_up();
   end
   initial
   begin
      #(25 * 400);
      bad_count++;
      wrap_up();
   end
endmodule : bsts_unit_tb
